/* File: gpt_pkg.sv */
package gpt_pkg;

  // Register indexes on the plain register port
  localparam logic [1:0]  GPT_OFS_CONTROL     = 2'h0;
  localparam logic [1:0]  GPT_OFS_COUNT_LOW   = 2'h1;
  localparam logic [1:0]  GPT_OFS_COUNT_HIGH  = 2'h2;
  localparam logic [1:0]  GPT_OFS_NB_CONTROL  = 2'h3;

  // Field positions of timer_control
  localparam int          GPT_BIT_RUN         = 15;
  localparam int          GPT_BIT_IDLE_STOP   = 13;
  localparam int          GPT_BIT_GATE        = 6;
  localparam int          GPT_BIT_PRESC_HI    = 5;
  localparam int          GPT_BIT_PRESC_LO    = 4;
  localparam int          GPT_BIT_PAIR_WIDE   = 3;
  localparam int          GPT_BIT_CLK_SRC     = 1;

  // Implemented bits, the rest read as zero
  localparam logic [15:0] GPT_CONTROL_MASK    = 16'ha07a;
  localparam logic [15:0] GPT_NB_CONTROL_MASK = 16'h8030;

  // Reset values and the full-scale count
  localparam logic [15:0] GPT_CONTROL_RST     = 16'h0000;
  localparam logic [15:0] GPT_COUNT_RST       = 16'h0000;
  localparam logic [15:0] GPT_COUNT_MAX       = 16'hffff;

  // Prescale selections and their terminal counts
  typedef enum logic [1:0] {
    GPT_PS_1   = 2'h0,
    GPT_PS_8   = 2'h1,
    GPT_PS_64  = 2'h2,
    GPT_PS_256 = 2'h3
  } gpt_presc_t;

  localparam logic [7:0]  GPT_PS_TERM_1       = 8'h00;
  localparam logic [7:0]  GPT_PS_TERM_8       = 8'h07;
  localparam logic [7:0]  GPT_PS_TERM_64      = 8'h3f;
  localparam logic [7:0]  GPT_PS_TERM_256     = 8'hff;

  function automatic logic [7:0] gpt_presc_term(input logic [1:0] sel);
    case (gpt_presc_t'(sel))
      GPT_PS_8:   gpt_presc_term = GPT_PS_TERM_8;
      GPT_PS_64:  gpt_presc_term = GPT_PS_TERM_64;
      GPT_PS_256: gpt_presc_term = GPT_PS_TERM_256;
      default:    gpt_presc_term = GPT_PS_TERM_1;
    endcase
  endfunction : gpt_presc_term

endpackage : gpt_pkg

/* File: gpt_pin_sync.sv */
`timescale 1ns/1ps
module gpt_pin_sync (
  // Clock and reset
  input  wire logic CLK_I,
  input  wire logic RESET_N_I,
  // Pin side
  input  wire logic pin_i,
  // Synchronised outputs
  output logic      level_o,
  output logic      rise_o
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // First flop feeds only the second one
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o  = sync_r & ~prev_r;

endmodule : gpt_pin_sync

/* File: gpt_prescaler.sv */
`timescale 1ns/1ps
module gpt_prescaler
  import gpt_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RESET_N_I,
  // Control
  input  wire logic       clear_i,
  input  wire logic       enable_i,
  input  wire logic [1:0] select_i,
  // Source and divided ticks
  input  wire logic       src_tick_i,
  output logic            tick_o
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       at_term;

  assign at_term = (cnt_r == gpt_presc_term(select_i));
  assign tick_o  = enable_i & src_tick_i & at_term;

  always_comb begin
    cnt_nxt = cnt_r;
    if (clear_i || !enable_i) begin
      cnt_nxt = 8'h00;
    end else if (src_tick_i) begin
      cnt_nxt = at_term ? 8'h00 : cnt_r + 8'h01;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : gpt_prescaler

/* File: gpt_timer.sv */
`timescale 1ns/1ps
// Overview of operation
// - In 16-bit mode the run bit starts counting; clearing it freezes the count.
// - Internal clock: gate bit enables gated accumulation; external clock: gate ignored.
// - Prescale field divides the counting clock by 1, 8, 64 or 256.
// - Pair bit joins this timer and its neighbour into one 32-bit counter.
// - Clock source bit picks the external clock pin, else the instruction clock.
module gpt_timer
  import gpt_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  // Register port
  input  wire logic [1:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RDATA_O,
  // Device state
  input  wire logic        IDLE_I,
  // External clock or gate pin
  input  wire logic        EXTERNAL_CLOCK_PIN_I,
  // Count state
  output logic      [15:0] COUNT_LOW_O,
  output logic      [15:0] COUNT_HIGH_O,
  output logic             PAIR_WIDE_MODE_O,
  output logic             WRAP_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [15:0] control_r;
  logic [15:0] control_nxt;
  logic [15:0] nb_control_r;
  logic [15:0] nb_control_nxt;
  logic [15:0] count_low_r;
  logic [15:0] count_low_nxt;
  logic [15:0] count_high_r;
  logic [15:0] count_high_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        wrap_r;
  logic        wrap_nxt;

  logic        wr_control;
  logic        wr_nb_control;
  logic        wr_low;
  logic        wr_high;

  logic        timer_run;
  logic        idle_stop;
  logic        gate_accumulate;
  logic [1:0]  prescale_select;
  logic        pair_wide_mode;
  logic        clock_source_select;
  logic        nb_run;
  logic [1:0]  nb_prescale_select;

  assign wr_control    = WR_I && (ADDR_I == GPT_OFS_CONTROL);
  assign wr_nb_control = WR_I && (ADDR_I == GPT_OFS_NB_CONTROL);
  assign wr_low        = WR_I && (ADDR_I == GPT_OFS_COUNT_LOW);
  assign wr_high       = WR_I && (ADDR_I == GPT_OFS_COUNT_HIGH);

  assign timer_run           = control_r[GPT_BIT_RUN];
  assign idle_stop           = control_r[GPT_BIT_IDLE_STOP];
  assign gate_accumulate     = control_r[GPT_BIT_GATE];
  assign prescale_select     = control_r[GPT_BIT_PRESC_HI:GPT_BIT_PRESC_LO];
  assign pair_wide_mode      = control_r[GPT_BIT_PAIR_WIDE];
  assign clock_source_select = control_r[GPT_BIT_CLK_SRC];
  assign nb_run              = nb_control_r[GPT_BIT_RUN];
  assign nb_prescale_select  = nb_control_r[GPT_BIT_PRESC_HI:GPT_BIT_PRESC_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Counting clock selection

  logic pin_level;
  logic pin_rise;
  logic low_src_tick;
  logic low_enable;
  logic low_tick;
  logic high_enable;
  logic high_tick;

  gpt_pin_sync u_pin_sync (
    .CLK_I     (CLK_I),
    .RESET_N_I (RESET_N_I),
    .pin_i     (EXTERNAL_CLOCK_PIN_I),
    .level_o   (pin_level),
    .rise_o    (pin_rise)
  );

  // Gate only qualifies the instruction clock; pin edges win when external
  always_comb begin
    if (clock_source_select) begin
      low_src_tick = pin_rise;
    end else if (gate_accumulate) begin
      low_src_tick = pin_level;
    end else begin
      low_src_tick = 1'b1;
    end
  end

  assign low_enable  = timer_run && !(idle_stop && IDLE_I);
  // Neighbour keeps its own run bit only while split
  assign high_enable = !pair_wide_mode && nb_run && !(idle_stop && IDLE_I);

  // Each control write restarts its own divider so a new ratio starts clean
  gpt_prescaler u_presc_low (
    .CLK_I      (CLK_I),
    .RESET_N_I  (RESET_N_I),
    .clear_i    (wr_control),
    .enable_i   (low_enable),
    .select_i   (prescale_select),
    .src_tick_i (low_src_tick),
    .tick_o     (low_tick)
  );

  gpt_prescaler u_presc_high (
    .CLK_I      (CLK_I),
    .RESET_N_I  (RESET_N_I),
    .clear_i    (wr_nb_control),
    .enable_i   (high_enable),
    .select_i   (nb_prescale_select),
    .src_tick_i (1'b1),
    .tick_o     (high_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counters and registers

  always_comb begin
    control_nxt    = control_r;
    nb_control_nxt = nb_control_r;
    count_low_nxt  = count_low_r;
    count_high_nxt = count_high_r;
    wrap_nxt       = 1'b0;
    if (wr_control) begin
      control_nxt = WDATA_I & GPT_CONTROL_MASK;
    end
    if (wr_nb_control) begin
      nb_control_nxt = WDATA_I & GPT_NB_CONTROL_MASK;
    end
    if (low_tick) begin
      count_low_nxt = count_low_r + 16'h0001;
      if (count_low_r == GPT_COUNT_MAX) begin
        if (pair_wide_mode) begin
          count_high_nxt = count_high_r + 16'h0001;
          wrap_nxt       = (count_high_r == GPT_COUNT_MAX);
        end else begin
          wrap_nxt = 1'b1;
        end
      end
    end
    if (high_tick) begin
      count_high_nxt = count_high_r + 16'h0001;
    end
    // Software load overrides a tick in the same cycle
    if (wr_low) begin
      count_low_nxt = WDATA_I;
    end
    if (wr_high) begin
      count_high_nxt = WDATA_I;
    end
  end

  always_comb begin
    case (ADDR_I)
      GPT_OFS_CONTROL:    rdata_nxt = control_r;
      GPT_OFS_COUNT_LOW:  rdata_nxt = count_low_r;
      GPT_OFS_COUNT_HIGH: rdata_nxt = count_high_r;
      GPT_OFS_NB_CONTROL: rdata_nxt = nb_control_r;
      default:            rdata_nxt = 16'h0000;
    endcase
    if (!RD_I) begin
      rdata_nxt = 16'h0000;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      control_r    <= GPT_CONTROL_RST;
      nb_control_r <= GPT_CONTROL_RST;
      count_low_r  <= GPT_COUNT_RST;
      count_high_r <= GPT_COUNT_RST;
      rdata_r      <= 16'h0000;
      wrap_r       <= 1'b0;
    end else begin
      control_r    <= control_nxt;
      nb_control_r <= nb_control_nxt;
      count_low_r  <= count_low_nxt;
      count_high_r <= count_high_nxt;
      rdata_r      <= rdata_nxt;
      wrap_r       <= wrap_nxt;
    end
  end

  assign RDATA_O          = rdata_r;
  assign COUNT_LOW_O      = count_low_r;
  assign COUNT_HIGH_O     = count_high_r;
  assign PAIR_WIDE_MODE_O = pair_wide_mode;
  assign WRAP_O           = wrap_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Gap since the last low tick; a control write may retune the ratio at once
  logic [3:0] tick_gap_r;
  logic [3:0] tick_gap_nxt;
  logic       tick_seen_r;
  logic       tick_seen_nxt;

  always_comb begin
    tick_gap_nxt  = tick_gap_r;
    tick_seen_nxt = tick_seen_r;
    if (low_tick || wr_control) begin
      tick_gap_nxt  = 4'h0;
      tick_seen_nxt = low_tick && !wr_control;
    end else if (tick_gap_r != 4'hf) begin
      tick_gap_nxt = tick_gap_r + 4'h1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      tick_gap_r  <= 4'h0;
      tick_seen_r <= 1'b0;
    end else begin
      tick_gap_r  <= tick_gap_nxt;
      tick_seen_r <= tick_seen_nxt;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence low_untouched_s;
    !wr_low && !wr_control;
  endsequence

  sequence low_held_s;
    ##1 (count_low_r == $past(count_low_r));
  endsequence

  sequence low_stepped_s;
    ##1 (count_low_r == $past(count_low_r) + 16'h0001);
  endsequence

  stop_holds_a: assert property (
    (!timer_run ##0 low_untouched_s) |-> low_held_s)
    else $error("count moved while stopped");

  run_counts_a: assert property (
    (timer_run && !idle_stop && !clock_source_select && !gate_accumulate
     && prescale_select == 2'h0 && !wr_low && !wr_control) |-> low_stepped_s)
    else $error("running 1:1 count did not step");

  idle_pause_a: assert property (
    (idle_stop && IDLE_I && !wr_low) |=> (count_low_r == $past(count_low_r)))
    else $error("count moved in idle with idle-stop set");

  idle_runs_a: assert property (
    (timer_run && !idle_stop && IDLE_I && !clock_source_select && !gate_accumulate
     && prescale_select == 2'h0 && !wr_low && !wr_control) |-> low_stepped_s)
    else $error("count paused in idle without idle-stop");

  gate_closed_a: assert property (
    (!clock_source_select && gate_accumulate && !pin_level && !wr_low) |-> low_held_s)
    else $error("gated count moved with gate low");

  presc_eight_a: assert property (
    (low_tick && prescale_select == 2'h1 && tick_seen_r) |-> (tick_gap_r >= 4'h7))
    else $error("1:8 prescale ticked early");

  pair_carry_a: assert property (
    (pair_wide_mode && low_tick && count_low_r == GPT_COUNT_MAX && !wr_high)
    |=> (count_high_r == $past(count_high_r) + 16'h0001))
    else $error("32-bit carry into high half missing");

  high_follows_a: assert property (
    (pair_wide_mode && !(low_tick && count_low_r == GPT_COUNT_MAX) && !wr_high)
    |=> $stable(count_high_r))
    else $error("high half moved without carry");

  ext_edge_a: assert property (
    (clock_source_select && low_tick) |-> pin_rise)
    else $error("external count without pin edge");

  gate_open_a: assert property (
    (timer_run && !idle_stop && !clock_source_select && gate_accumulate && pin_level
     && prescale_select == 2'h0 && !wr_low && !wr_control) |-> low_stepped_s)
    else $error("gated count stalled with gate high");

  wrap_single_a: assert property (
    (!pair_wide_mode && low_tick && count_low_r == GPT_COUNT_MAX) |=> wrap_r)
    else $error("16-bit wrap pulse missing");

  split_neighbour_a: assert property (
    (!pair_wide_mode && !nb_run && !wr_high) |=> $stable(count_high_r))
    else $error("stopped neighbour half moved");

endmodule : gpt_timer

/* File: gpt_pin_model.sv */
`timescale 1ns/1ps
module gpt_pin_model (
  // Clock
  input  wire logic clk_i,
  // Behaviour
  input  wire logic toggle_i,
  input  wire logic level_i,
  input  wire logic [7:0] half_i,
  // Pin side
  output logic      pin_o
);
  int cnt;

  initial begin
    pin_o = 1'b0;
    cnt   = 0;
  end

  // Holds a level for gating, or toggles every half_i cycles as a source clock
  always @(posedge clk_i) begin
    if (!toggle_i) begin
      pin_o <= level_i;
      cnt   <= 0;
    end else if (cnt + 1 >= int'(half_i)) begin
      pin_o <= ~pin_o;
      cnt   <= 0;
    end else begin
      cnt   <= cnt + 1;
    end
  end
endmodule : gpt_pin_model

/* File: tb_gated_prescaled_timer.sv */
`timescale 1ns/1ps
module tb_gated_prescaled_timer;
  import gpt_pkg::*;

  logic        clk, rst_n, wr, rd, idle, pin, pair, wrap, tog, lvl;
  logic [1:0]  addr;
  logic [15:0] wdata, rdata, lo, hi, r16;
  logic [7:0]  half;
  int          fails, checked, seed, k, r;

  gpt_timer dut_u (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .IDLE_I(idle), .EXTERNAL_CLOCK_PIN_I(pin), .COUNT_LOW_O(lo),
    .COUNT_HIGH_O(hi), .PAIR_WIDE_MODE_O(pair), .WRAP_O(wrap));
  gpt_pin_model pin_u (.clk_i(clk), .toggle_i(tog), .level_i(lvl), .half_i(half), .pin_o(pin));

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic int ratio(input int ps);
    return (ps == 0) ? 1 : (ps == 1) ? 8 : (ps == 2) ? 64 : 256;
  endfunction : ratio

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic wreg(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rreg

  // Window of n cycles, count_low must advance by exactly exp
  task automatic span(input int n, input logic [15:0] exp);
    logic [15:0] a;
    @(posedge clk);
    #1 a = lo;
    repeat (n) @(posedge clk);
    #1 chk(lo - a, exp);
    @(posedge clk);
  endtask : span

  // Bounded wait, a missed event counts as a mismatch
  task automatic wait_for(input bit on_wrap);
    int i;
    for (i = 0; i < 20 && (on_wrap ? wrap !== 1'b1 : lo === 16'hffff); i++) begin
      @(posedge clk);
      #1;
    end
    chk({15'h0, (on_wrap ? wrap : lo !== 16'hffff)}, 16'h1);
    if (i >= 20) tally_and_finish();
  endtask : wait_for

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0; rst_n = 0; wr = 0; rd = 0; idle = 0; addr = 0; wdata = 0;
    tog = 0; lvl = 0; half = 8'h02; fails = 0; checked = 0; seed = 84;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rreg(GPT_OFS_CONTROL, 16'h0000);
    rreg(GPT_OFS_COUNT_LOW, 16'h0000);
    rreg(GPT_OFS_COUNT_HIGH, 16'h0000);
    wreg(GPT_OFS_CONTROL, 16'h7fff);
    rreg(GPT_OFS_CONTROL, 16'h207a);
    wreg(GPT_OFS_NB_CONTROL, 16'h7fff);
    rreg(GPT_OFS_NB_CONTROL, 16'h0030);
    wreg(GPT_OFS_NB_CONTROL, 16'h0000);
    // Every prescale code, random start value and window length
    for (int ps = 0; ps < 4; ps++) begin
      r = ratio(ps);
      k = ($random(seed) & 3) + 1;
      wreg(GPT_OFS_COUNT_LOW, 16'($random(seed)));
      wreg(GPT_OFS_CONTROL, 16'h8000 | 16'(ps << 4));
      repeat (r + 4) @(posedge clk);
      span(k * r, 16'(k));
      wreg(GPT_OFS_CONTROL, 16'(ps << 4));
      repeat (2) @(posedge clk);
      span(2 * r + 5, 16'h0);
    end
    idle <= 1'b1;
    wreg(GPT_OFS_CONTROL, 16'ha000);
    repeat (4) @(posedge clk);
    span(20, 16'h0);
    wreg(GPT_OFS_CONTROL, 16'h8000);
    repeat (4) @(posedge clk);
    span(20, 16'd20);
    idle <= 1'b0;
    // Gate held low then high through the pin synchroniser
    wreg(GPT_OFS_CONTROL, 16'h8040);
    repeat (6) @(posedge clk);
    span(20, 16'h0);
    lvl <= 1'b1;
    repeat (6) @(posedge clk);
    span(20, 16'd20);
    lvl <= 1'b0;
    // External source, prompt and slow pin clock, gate bit set but ignored
    tog <= 1'b1;
    for (int h = 2; h < 10; h += 5) begin
      half <= 8'(h);
      for (int ps = 0; ps < 2; ps++) begin
        r = ratio(ps) * 2 * h;
        wreg(GPT_OFS_CONTROL, 16'h8042 | 16'(ps << 4));
        repeat (r + 8) @(posedge clk);
        span(2 * r, 16'd2);
      end
    end
    tog <= 1'b0;
    // Wrap in 16-bit mode leaves the stopped neighbour alone
    r16 = 16'($random(seed));
    wreg(GPT_OFS_CONTROL, 16'h0000);
    wreg(GPT_OFS_COUNT_LOW, 16'hffff);
    wreg(GPT_OFS_COUNT_HIGH, r16);
    wreg(GPT_OFS_CONTROL, 16'h8000);
    wait_for(1'b1);
    wreg(GPT_OFS_CONTROL, 16'h0000);
    rreg(GPT_OFS_COUNT_HIGH, r16);
    // Paired: low carry feeds the high half
    wreg(GPT_OFS_COUNT_LOW, 16'hffff);
    wreg(GPT_OFS_CONTROL, 16'h8008);
    wait_for(1'b0);
    chk(hi, r16 + 16'h1);
    chk({15'h0, pair}, 16'h1);
    wreg(GPT_OFS_CONTROL, 16'h0008);
    wreg(GPT_OFS_COUNT_LOW, 16'hffff);
    wreg(GPT_OFS_COUNT_HIGH, 16'hffff);
    wreg(GPT_OFS_CONTROL, 16'h8008);
    wait_for(1'b1);
    chk(hi, 16'h0000);
    tally_and_finish();
  end
endmodule : tb_gated_prescaled_timer
